// [adfp_defs.svh]
`ifndef ADFP_DEFS_SVH
`define ADFP_DEFS_SVH

// ==========================================
// register indices (byte address is index times four)
`define ADFP_IDX_PAT_LOW 6'h20
`define ADFP_IDX_PAT_MID 6'h21
`define ADFP_IDX_PAT_HIGH 6'h22
`define ADFP_IDX_FEATURE 6'h24
`define ADFP_IDX_DECIM 6'h25

// ==========================================
// feature_path_control fields
`define ADFP_AVG_BIT 5
`define ADFP_SEL_HI 4
`define ADFP_SEL_LO 3
`define ADFP_PATH_BIT 2
`define ADFP_FEN_BIT 1
`define ADFP_FEATURE_MASK 8'h3E

// ==========================================
// decimation_control fields
`define ADFP_SELEN_BIT 7
`define ADFP_DEC_HI 6
`define ADFP_DEC_LO 4
`define ADFP_REAL_BIT 3
`define ADFP_PHASE_BIT 0
`define ADFP_DECIM_MASK 8'hF9
`define ADFP_PAT_HIGH_MASK 8'h0F

// ==========================================
// reset values and codes
`define ADFP_RST_BYTE 8'h00
`define ADFP_SEL_AVG 2'b11
`define ADFP_SEL_A 2'b01
`define ADFP_SEL_B 2'b10
`define ADFP_DEC_BYPASS 3'b000
`define ADFP_DEC_MAX 3'b101
`define ADFP_PAT_ALL 20'hF_FFFF
`define ADFP_PAT_ONES_BASE 5'h07
`define ADFP_RESP_OKAY 2'b00
`define ADFP_RESP_SLVERR 2'b10

`endif

// [adfp_pkg.sv]
package adfp_pkg;
    typedef logic [7:0] adfp_byte_t;
    typedef logic [19:0] adfp_pat_t;
    typedef logic [1:0] adfp_sel_t;
    typedef logic [2:0] adfp_dec_t;
    typedef logic [1:0] adfp_res_t;
endpackage

// [adfp_avg.sv]
`timescale 1ns/1ps
module adfp_avg #(
    parameter int SW = 14
) (
    // samples
    input wire logic signed [SW-1:0] chanA,
    input wire logic signed [SW-1:0] chanB,
    // average
    output logic signed [SW-1:0] average
);
    logic signed [SW:0] sum;
    logic signed [SW:0] half;

    // ==========================================
    // sum then halve, arithmetic
    assign sum = {chanA[SW-1], chanA} + {chanB[SW-1], chanB};
    assign half = sum >>> 1;
    assign average = half[SW-1:0];
endmodule

// [adfp_config.sv]
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "adfp_defs.svh"
module adfp_config #(
    parameter int SW = 14,
    parameter int PW = 32
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // converter samples
    input wire logic sampleValid,
    input wire logic signed [SW-1:0] sampleA,
    input wire logic signed [SW-1:0] sampleB,
    input wire logic [PW-1:0] ncoPhase,
    input wire adfp_pkg::adfp_res_t outputResolution,
    // bypass stream
    output logic bypassValid,
    output logic signed [SW-1:0] bypassA,
    output logic signed [SW-1:0] bypassB,
    // filter inputs
    output logic filterValid,
    output logic decimValid,
    output logic signed [SW-1:0] filterInA,
    output logic signed [SW-1:0] filterInB,
    output logic [PW-1:0] ncoPhaseOut,
    // configuration
    output adfp_pkg::adfp_pat_t framePattern,
    output adfp_pkg::adfp_dec_t decimationCode,
    output logic realMode
);
    import adfp_pkg::*;

    typedef struct packed {
        adfp_byte_t patLow;
        adfp_byte_t patMid;
        adfp_byte_t patHigh;
        adfp_byte_t feature;
        adfp_byte_t decim;
        logic awHeld;
        logic [7:0] awAddr;
        logic wHeld;
        adfp_byte_t wByte;
        logic wLane;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        adfp_byte_t rByte;
        logic [1:0] rResp;
        logic bypValid;
        logic signed [SW-1:0] bypA;
        logic signed [SW-1:0] bypB;
        logic filtValid;
        logic decValid;
        logic signed [SW-1:0] filtA;
        logic signed [SW-1:0] filtB;
        logic [PW-1:0] phase;
        logic [4:0] decCount;
        adfp_pat_t pattern;
    } adfp_state_t;

    adfp_state_t st;
    adfp_state_t next_st;
    logic signed [SW-1:0] avgOut;

    // ==========================================
    // averaging
    adfp_avg #(
        .SW(SW)
    ) i_adfp_avg (
        .chanA(sampleA),
        .chanB(sampleB),
        .average(avgOut)
    );

    // ==========================================
    // field views
    logic avgEnable;
    logic featurePathSelect;
    logic filterEnable;
    logic inputSelectEnable;
    logic phaseInvert;
    adfp_sel_t filterInputSelect;
    adfp_sel_t routeSel;
    adfp_dec_t decCode;
    logic [4:0] decMask;
    logic [4:0] patOnes;
    adfp_pat_t autoPattern;
    adfp_pat_t progPattern;

    assign avgEnable = st.feature[`ADFP_AVG_BIT];
    assign filterInputSelect = st.feature[`ADFP_SEL_HI:`ADFP_SEL_LO];
    assign featurePathSelect = st.feature[`ADFP_PATH_BIT];
    assign filterEnable = st.feature[`ADFP_FEN_BIT];
    assign inputSelectEnable = st.decim[`ADFP_SELEN_BIT];
    assign decCode = st.decim[`ADFP_DEC_HI:`ADFP_DEC_LO];
    assign phaseInvert = st.decim[`ADFP_PHASE_BIT];
    // selector code only counts while enabled
    assign routeSel = inputSelectEnable ? filterInputSelect : 2'h0;
    assign patOnes = `ADFP_PAT_ONES_BASE + {3'h0, outputResolution};
    assign autoPattern = ~(`ADFP_PAT_ALL >> patOnes);
    assign progPattern = {st.patHigh[3:0], st.patMid, st.patLow};

    // divider mask per decimation ratio, unused codes act as bypass
    always_comb begin
        case (decCode)
            3'h1: decMask = 5'h01;
            3'h2: decMask = 5'h03;
            3'h3: decMask = 5'h07;
            3'h4: decMask = 5'h0F;
            3'h5: decMask = 5'h1F;
            default: decMask = 5'h00;
        endcase
    end

    // ==========================================
    // bus handshake
    logic awFire;
    logic wFire;
    logic arFire;
    logic haveAw;
    logic haveW;
    logic [7:0] wrAddr;
    adfp_byte_t wrByte;
    logic wrLane;
    logic wrMapped;
    logic rdMapped;
    adfp_byte_t rdByte;

    assign awready = !st.awHeld && !st.bValid;
    assign wready = !st.wHeld && !st.bValid;
    assign arready = !st.rValid;
    assign awFire = awvalid && awready;
    assign wFire = wvalid && wready;
    assign arFire = arvalid && arready;
    assign haveAw = st.awHeld || awFire;
    assign haveW = st.wHeld || wFire;
    assign wrAddr = st.awHeld ? st.awAddr : awaddr;
    assign wrByte = st.wHeld ? st.wByte : wdata[7:0];
    assign wrLane = st.wHeld ? st.wLane : wstrb[0];

    function automatic logic isMapped(input logic [7:0] addr);
        logic [5:0] idx;
        idx = addr[7:2];
        isMapped = (idx == `ADFP_IDX_PAT_LOW) || (idx == `ADFP_IDX_PAT_MID) ||
            (idx == `ADFP_IDX_PAT_HIGH) || (idx == `ADFP_IDX_FEATURE) ||
            (idx == `ADFP_IDX_DECIM);
    endfunction

    assign wrMapped = isMapped(wrAddr);
    assign rdMapped = isMapped(araddr);

    always_comb begin
        case (araddr[7:2])
            `ADFP_IDX_PAT_LOW: rdByte = st.patLow;
            `ADFP_IDX_PAT_MID: rdByte = st.patMid;
            `ADFP_IDX_PAT_HIGH: rdByte = st.patHigh;
            `ADFP_IDX_FEATURE: rdByte = st.feature;
            `ADFP_IDX_DECIM: rdByte = st.decim;
            default: rdByte = `ADFP_RST_BYTE;
        endcase
    end

    // ==========================================
    // next state
    always_comb begin
        next_st = st;
        // write channel
        if (awFire) begin
            next_st.awHeld = 1'b1;
            next_st.awAddr = awaddr;
        end
        if (wFire) begin
            next_st.wHeld = 1'b1;
            next_st.wByte = wdata[7:0];
            next_st.wLane = wstrb[0];
        end
        if (haveAw && haveW) begin
            next_st.awHeld = 1'b0;
            next_st.wHeld = 1'b0;
            next_st.bValid = 1'b1;
            next_st.bResp = wrMapped ? `ADFP_RESP_OKAY : `ADFP_RESP_SLVERR;
            if (wrLane) begin
                case (wrAddr[7:2])
                    `ADFP_IDX_PAT_LOW: next_st.patLow = wrByte;
                    `ADFP_IDX_PAT_MID: next_st.patMid = wrByte;
                    `ADFP_IDX_PAT_HIGH: next_st.patHigh = wrByte & `ADFP_PAT_HIGH_MASK;
                    `ADFP_IDX_FEATURE: next_st.feature = wrByte & `ADFP_FEATURE_MASK;
                    `ADFP_IDX_DECIM: next_st.decim = wrByte & `ADFP_DECIM_MASK;
                    default: next_st.bResp = `ADFP_RESP_SLVERR;
                endcase
            end
        end else if (st.bValid && bready) begin
            next_st.bValid = 1'b0;
        end
        // read channel
        if (arFire) begin
            next_st.rValid = 1'b1;
            next_st.rByte = rdByte;
            next_st.rResp = rdMapped ? `ADFP_RESP_OKAY : `ADFP_RESP_SLVERR;
        end else if (st.rValid && rready) begin
            next_st.rValid = 1'b0;
        end
        // frame pattern, automatic only in bypass
        next_st.pattern = (decCode == `ADFP_DEC_BYPASS) ? autoPattern : progPattern;
        // sample path
        next_st.bypValid = sampleValid && !featurePathSelect;
        next_st.filtValid = sampleValid && featurePathSelect && filterEnable;
        next_st.decValid = 1'b0;
        if (sampleValid && !featurePathSelect) begin
            next_st.bypA = sampleA;
            next_st.bypB = sampleB;
        end
        if (sampleValid && featurePathSelect) begin
            case (routeSel)
                `ADFP_SEL_A: begin
                    next_st.filtA = sampleA;
                    next_st.filtB = sampleA;
                end
                `ADFP_SEL_B: begin
                    next_st.filtA = sampleB;
                    next_st.filtB = sampleB;
                end
                `ADFP_SEL_AVG: begin
                    next_st.filtA = avgEnable ? avgOut : sampleA;
                    next_st.filtB = avgEnable ? avgOut : sampleB;
                end
                default: begin
                    next_st.filtA = sampleA;
                    next_st.filtB = sampleB;
                end
            endcase
            // real mode does no mixing
            if (st.decim[`ADFP_REAL_BIT]) begin
                next_st.phase = '0;
            end else begin
                next_st.phase = phaseInvert ? ~ncoPhase : ncoPhase;
            end
        end
        // decimation divider on filtered samples
        if (sampleValid && featurePathSelect && filterEnable) begin
            next_st.decValid = ((st.decCount & decMask) == decMask);
            next_st.decCount = 5'((st.decCount + 5'h01) & decMask);
        end
        if (!filterEnable) begin
            next_st.decCount = 5'h00;
        end
    end

    // ==========================================
    // state register
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================
    // outputs
    assign bvalid = st.bValid;
    assign bresp = st.bResp;
    assign rvalid = st.rValid;
    assign rdata = {24'h00_0000, st.rByte};
    assign rresp = st.rResp;
    assign bypassValid = st.bypValid;
    assign bypassA = st.bypA;
    assign bypassB = st.bypB;
    assign filterValid = st.filtValid;
    assign decimValid = st.decValid;
    assign filterInA = st.filtA;
    assign filterInB = st.filtB;
    assign ncoPhaseOut = st.phase;
    assign framePattern = st.pattern;
    assign decimationCode = decCode;
    assign realMode = st.decim[`ADFP_REAL_BIT];

    // ==========================================
    // checks
    sequence seqFeatureSample;
        sampleValid && featurePathSelect;
    endsequence

    sequence seqWriteDone;
        (awvalid && awready && wvalid && wready) ##1 bvalid;
    endsequence

    chk_pattern_auto: assert property (@(posedge clock) disable iff (!reset_n)
        (decCode == `ADFP_DEC_BYPASS) && $stable(decCode) && $stable(outputResolution)
        |=> framePattern == $past(autoPattern))
        else $error("frame pattern not automatic in bypass");

    chk_pattern_prog: assert property (@(posedge clock) disable iff (!reset_n)
        (decCode != `ADFP_DEC_BYPASS) |=> framePattern == $past(progPattern))
        else $error("frame pattern not taken from registers");

    chk_avg_value: assert property (@(posedge clock) disable iff (!reset_n)
        seqFeatureSample ##0 (routeSel == `ADFP_SEL_AVG) && avgEnable
        |=> filterInA == filterInB && 2 * int'(filterInA) ==
        int'($past(sampleA)) + int'($past(sampleB)) -
        ((int'($past(sampleA)) + int'($past(sampleB))) & 1))
        else $error("average output wrong");

    chk_sel_dup_a: assert property (@(posedge clock) disable iff (!reset_n)
        seqFeatureSample ##0 (routeSel == `ADFP_SEL_A)
        |=> filterInA == $past(sampleA) && filterInB == $past(sampleA))
        else $error("selector code 01 routing wrong");

    chk_sel_gated: assert property (@(posedge clock) disable iff (!reset_n)
        seqFeatureSample ##0 !inputSelectEnable
        |=> filterInA == $past(sampleA) && filterInB == $past(sampleB))
        else $error("selector acted while disabled");

    chk_bypass_path: assert property (@(posedge clock) disable iff (!reset_n)
        sampleValid && !featurePathSelect
        |=> bypassValid && !filterValid && bypassB == $past(sampleB))
        else $error("bypass path wrong");

    chk_filter_gate: assert property (@(posedge clock) disable iff (!reset_n)
        !filterEnable |=> !filterValid && !decimValid)
        else $error("filter ran while disabled");

    chk_decim_ratio: assert property (@(posedge clock) disable iff (!reset_n)
        decimValid && (decCode == 3'h1) && $stable(decCode) ##1 filterValid [*2]
        |-> decimValid)
        else $error("divide by two strobe wrong");

    chk_real_phase: assert property (@(posedge clock) disable iff (!reset_n)
        seqFeatureSample ##0 realMode |=> ncoPhaseOut == '0)
        else $error("mixing phase active in real mode");

    chk_phase_inv: assert property (@(posedge clock) disable iff (!reset_n)
        seqFeatureSample ##0 !realMode ##0 phaseInvert
        |=> ncoPhaseOut == ~$past(ncoPhase))
        else $error("phase not inverted");

    chk_reserved_zero: assert property (@(posedge clock) disable iff (!reset_n)
        seqWriteDone |-> (st.feature & ~`ADFP_FEATURE_MASK) == 8'h00 &&
        (st.decim & ~`ADFP_DECIM_MASK) == 8'h00 && st.patHigh[7:4] == 4'h0)
        else $error("reserved bits not zero");
endmodule

// [adfp_capture.sv]
`timescale 1ns/1ps
module adfp_capture (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // sample strobes from the block
    input wire logic bypassValid,
    input wire logic filterValid,
    input wire logic decimValid,
    // running counts
    output int nBypass,
    output int nFilter,
    output int nDecim
);
    // ==========================================
    // capture side: counts every strobe it is handed
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            nBypass <= 0;
            nFilter <= 0;
            nDecim <= 0;
        end else begin
            nBypass <= nBypass + int'(bypassValid);
            nFilter <= nFilter + int'(filterValid);
            nDecim <= nDecim + int'(decimValid);
        end
    end
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
`include "adfp_defs.svh"
module tb_top;
    import adfp_pkg::*;
    // ==========================================
    // signals
    logic clock = 0, reset_n = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, sampleValid = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, ncoPhase = 0;
    logic [3:0] wstrb = 0;
    logic signed [13:0] sampleA = 0, sampleB = 0;
    adfp_res_t outputResolution = 0;
    logic awready, wready, bvalid, arready, rvalid, bypassValid, filterValid;
    logic decimValid, realMode;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, ncoPhaseOut;
    logic signed [13:0] bypassA, bypassB, filterInA, filterInB;
    adfp_pat_t framePattern;
    adfp_dec_t decimationCode;
    int nBypass, nFilter, nDecim;
    int err_total = 0, total_checks = 0;
    localparam logic [7:0] A_LOW = {`ADFP_IDX_PAT_LOW, 2'b00};
    localparam logic [7:0] A_MID = {`ADFP_IDX_PAT_MID, 2'b00};
    localparam logic [7:0] A_HIGH = {`ADFP_IDX_PAT_HIGH, 2'b00};
    localparam logic [7:0] A_FEAT = {`ADFP_IDX_FEATURE, 2'b00};
    localparam logic [7:0] A_DEC = {`ADFP_IDX_DECIM, 2'b00};
    localparam logic [19:0] AUTO_PAT [4] = '{20'hF_E000, 20'hF_F000, 20'hF_F800, 20'hF_FC00};

    always #20 clock = ~clock;

    adfp_config #(.SW(14), .PW(32)) i_adfp_config (.clock(clock), .reset_n(reset_n),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .sampleValid(sampleValid),
        .sampleA(sampleA), .sampleB(sampleB), .ncoPhase(ncoPhase),
        .outputResolution(outputResolution), .bypassValid(bypassValid),
        .bypassA(bypassA), .bypassB(bypassB), .filterValid(filterValid),
        .decimValid(decimValid), .filterInA(filterInA), .filterInB(filterInB),
        .ncoPhaseOut(ncoPhaseOut), .framePattern(framePattern),
        .decimationCode(decimationCode), .realMode(realMode));

    adfp_capture i_adfp_capture (.clock(clock), .reset_n(reset_n),
        .bypassValid(bypassValid), .filterValid(filterValid), .decimValid(decimValid),
        .nBypass(nBypass), .nFilter(nFilter), .nDecim(nDecim));

    // ==========================================
    // compare and bus tasks
    task automatic cmp_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic cmp_cnt(input string nm, input int exp, input int got);
        total_checks++;
        if (got != exp) begin
            err_total++;
            $display("mismatch %s expected %0d seen %0d", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ta, tw, ah, dh;
        logic [1:0] r;
        ah = 0;
        dh = 0;
        @(posedge clock);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ah && dh)) begin
            @(negedge clock);
            ta = awvalid && awready;
            tw = wvalid && wready;
            @(posedge clock);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            ah = ah | ta;
            dh = dh | tw;
        end
        do @(negedge clock); while (!bvalid);
        r = bresp;
        @(posedge clock);
        bready <= 1'b0;
        cmp_val("bresp", {30'h0, er}, {30'h0, r});
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge clock); while (!arready);
        @(posedge clock);
        arvalid <= 1'b0;
        do @(negedge clock); while (!rvalid);
        d = rdata;
        r = rresp;
        @(posedge clock);
        rready <= 1'b0;
        cmp_val("rdata", {24'h00_0000, exp}, d);
        cmp_val("rresp", {30'h0, er}, {30'h0, r});
    endtask

    task automatic smp(input logic signed [13:0] a, input logic signed [13:0] b);
        @(posedge clock);
        sampleA <= a;
        sampleB <= b;
        sampleValid <= 1'b1;
        @(posedge clock);
        sampleValid <= 1'b0;
        repeat (2) @(posedge clock);
        @(negedge clock);
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset();
        rd(A_FEAT, 8'h00, 2'b00);
        rd(A_DEC, 8'h00, 2'b00);
        rd(A_LOW, 8'h00, 2'b00);
        for (int r = 0; r < 4; r++) begin
            @(posedge clock);
            outputResolution <= 2'(r);
            repeat (2) @(negedge clock);
            cmp_val("autoPattern", {12'h000, AUTO_PAT[r]}, {12'h000, framePattern});
        end
        @(posedge clock);
        outputResolution <= 2'b00;
    endtask

    task automatic t_regs();
        wr(A_FEAT, 8'hFF, 2'b00);
        rd(A_FEAT, 8'h3E, 2'b00);
        wr(A_DEC, 8'hFF, 2'b00);
        rd(A_DEC, 8'hF9, 2'b00);
        wr(A_HIGH, 8'hFF, 2'b00);
        rd(A_HIGH, 8'h0F, 2'b00);
        wr(8'h98, 8'h55, 2'b10);
        rd(8'h98, 8'h00, 2'b10);
        wr(A_FEAT, 8'h00, 2'b00);
        wr(A_DEC, 8'h00, 2'b00);
    endtask

    task automatic t_pattern();
        @(posedge clock);
        ncoPhase <= 32'h0000_0000;
        wr(A_DEC, 8'h18, 2'b00);
        wr(A_LOW, 8'h00, 2'b00);
        wr(A_MID, 8'hF8, 2'b00);
        wr(A_HIGH, 8'h0F, 2'b00);
        @(negedge clock);
        cmp_val("decimationCode", 32'h0000_0001, {29'h0, decimationCode});
        cmp_val("realMode", 32'h0000_0001, {31'h0, realMode});
        cmp_val("framePattern", 32'h000F_F800, {12'h000, framePattern});
        wr(A_DEC, 8'h10, 2'b00);
        wr(A_LOW, 8'hFF, 2'b00);
        wr(A_MID, 8'hFF, 2'b00);
        @(negedge clock);
        cmp_val("realMode", 32'h0000_0000, {31'h0, realMode});
        cmp_val("framePattern", 32'h000F_FFFF, {12'h000, framePattern});
        wr(A_DEC, 8'h00, 2'b00);
        @(negedge clock);
        cmp_val("framePattern", 32'h000F_E000, {12'h000, framePattern});
    endtask

    task automatic t_route();
        logic signed [13:0] ea, eb;
        for (int s = 0; s < 4; s++) begin
            wr(A_FEAT, 8'h06 | 8'(s << 3), 2'b00);
            wr(A_DEC, 8'h80, 2'b00);
            smp(14'sd100, -14'sd200);
            ea = (s == 2) ? -14'sd200 : 14'sd100;
            eb = (s == 1) ? 14'sd100 : -14'sd200;
            cmp_val("filterInA", ea, filterInA);
            cmp_val("filterInB", eb, filterInB);
        end
        wr(A_FEAT, 8'h0E, 2'b00);
        wr(A_DEC, 8'h00, 2'b00);
        smp(14'sd100, -14'sd200);
        cmp_val("filterInB", -14'sd200, filterInB);
        wr(A_FEAT, 8'h3E, 2'b00);
        wr(A_DEC, 8'h80, 2'b00);
        smp(-14'sd7, 14'sd2);
        cmp_val("filterInA", -14'sd3, filterInA);
        cmp_val("filterInB", -14'sd3, filterInB);
    endtask

    task automatic t_path();
        int b0, f0;
        wr(A_FEAT, 8'h00, 2'b00);
        wr(A_DEC, 8'h00, 2'b00);
        b0 = nBypass;
        f0 = nFilter;
        smp(14'sd33, -14'sd44);
        cmp_cnt("nBypass", b0 + 1, nBypass);
        cmp_cnt("nFilter", f0, nFilter);
        cmp_val("bypassA", 14'sd33, bypassA);
        cmp_val("bypassB", -14'sd44, bypassB);
        wr(A_FEAT, 8'h04, 2'b00);
        smp(14'sd5, 14'sd6);
        cmp_cnt("nBypass", b0 + 1, nBypass);
        cmp_cnt("nFilter", f0, nFilter);
        wr(A_FEAT, 8'h06, 2'b00);
        smp(14'sd5, 14'sd6);
        cmp_cnt("nFilter", f0 + 1, nFilter);
    endtask

    task automatic t_decim();
        int d0;
        wr(A_FEAT, 8'h00, 2'b00);
        wr(A_FEAT, 8'h06, 2'b00);
        for (int c = 5; c >= 0; c--) begin
            wr(A_DEC, 8'(c << 4), 2'b00);
            d0 = nDecim;
            @(posedge clock);
            sampleA <= 14'sd1;
            sampleB <= 14'sd2;
            sampleValid <= 1'b1;
            repeat (32) @(posedge clock);
            sampleValid <= 1'b0;
            repeat (3) @(posedge clock);
            @(negedge clock);
            cmp_cnt("nDecim", 32 >> c, nDecim - d0);
        end
    endtask

    task automatic t_phase();
        @(posedge clock);
        ncoPhase <= 32'h1234_5678;
        wr(A_DEC, 8'h00, 2'b00);
        smp(14'sd1, 14'sd1);
        cmp_val("ncoPhaseOut", 32'h1234_5678, ncoPhaseOut);
        wr(A_DEC, 8'h01, 2'b00);
        smp(14'sd1, 14'sd1);
        cmp_val("phaseChanged", 32'h0000_0001, {31'h0, ncoPhaseOut !== 32'h1234_5678});
        wr(A_DEC, 8'h08, 2'b00);
        smp(14'sd1, 14'sd1);
        cmp_val("ncoPhaseOut", 32'h0000_0000, ncoPhaseOut);
    endtask

    // ==========================================
    // run control
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        t_reset();
        t_regs();
        t_pattern();
        t_route();
        t_path();
        t_decim();
        t_phase();
        test_done();
    end

    initial begin
        #(40 * 40000);
        err_total++;
        test_done();
    end
endmodule
